/* File: scp_pkg.sv */
package scp_pkg;

	// ----------------------------------------
	// option bits and counts
	// ----------------------------------------
	localparam int OPT_WIDTH = 16;
	localparam int OPT_LS_THRESH_BIT = 7;
	localparam int OPT_HS_ENABLE_BIT = 8;
	localparam int SHORT_LIMIT = 7;
	localparam int CNT_WIDTH = 3;
	localparam logic [CNT_WIDTH-1:0] CNT_RESET = 3'h0;
	localparam logic [CNT_WIDTH-1:0] CNT_LAST = 3'(SHORT_LIMIT - 1);

	// thresholds in millivolts, selected by option bits
	localparam int LS_THRESH_LO_MV = 135;
	localparam int LS_THRESH_HI_MV = 230;
	localparam int HS_THRESH_MV = 750;
	localparam int MV_WIDTH = 12;

	// blanking count in switching-clock cycles after gate turn-on
	localparam int BLANK_CYCLES = 2;
	localparam int BLANK_WIDTH = 2;
	// sensed drops lag two sync stages, so the count covers that lag in full
	localparam logic [BLANK_WIDTH-1:0] BLANK_LAST = 2'(BLANK_CYCLES);

	// ----------------------------------------
	// converter phases
	// ----------------------------------------
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_HIGH = 2'h1,
		PH_LOW = 2'h3,
		PH_OFF = 2'h2
	} phase_t;

endpackage : scp_pkg

/* File: short_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module short_counter (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic trip,
	output logic limit_hit
);
	import scp_pkg::*;

	logic [CNT_WIDTH-1:0] count_reg;

	// ----------------------------------------
	// event count
	// ----------------------------------------
	// counts comparator trips
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= CNT_RESET;
		end else if (clear) begin
			count_reg <= CNT_RESET;
		end else if (trip && count_reg != CNT_LAST) begin
			count_reg <= count_reg + 3'h1;
		end
	end

	assign limit_hit = trip && !clear && (count_reg == CNT_LAST);

endmodule : short_counter

`default_nettype wire

/* File: short_protect.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - check each cycle after blanking time
// - two comparators, each with own counter
// - seventh short event latches charger off
// - only adapter reconnect clears the latch
// - negative low-side drop never trips
// - positive low-side drop over threshold trips
// - low side senses switch node to ground
// - high side senses adapter-sense to switch node
// - option bit 7 picks 135 or 230 mV
// - option bit 8 enables 750 mV high check
// - non-synchronous mode keeps bottom gate off, except for one cycle on leaving idle with PWM low
// - light load: bottom off except bootstrap refresh and one cycle on leaving idle with PWM low
module short_protect (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic adapter_present,
	input wire logic [scp_pkg::OPT_WIDTH-1:0] option_control_register,
	input wire logic nonsync_mode,
	input wire logic light_load,
	input wire logic bootstrap_refresh,
	input wire logic pwm_high,
	input wire logic signed [scp_pkg::MV_WIDTH:0] adapter_sense_pos_pin_mv,
	input wire logic signed [scp_pkg::MV_WIDTH:0] phase_node_mv,
	output logic high_gate,
	output logic low_gate,
	output logic latched_off,
	output logic hs_trip,
	output logic ls_trip
);
	import scp_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic adapter_s1_reg;
	logic adapter_s2_reg;
	logic adapter_prev_reg;
	logic [1:0] opt_s1_reg;
	logic [1:0] opt_s2_reg;
	logic [2:0] mode_s1_reg;
	logic [2:0] mode_s2_reg;
	logic pwm_s1_reg;
	logic pwm_s2_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			adapter_s1_reg <= 1'b0;
			adapter_s2_reg <= 1'b0;
			adapter_prev_reg <= 1'b0;
			opt_s1_reg <= 2'h0;
			opt_s2_reg <= 2'h0;
			mode_s1_reg <= 3'h0;
			mode_s2_reg <= 3'h0;
			pwm_s1_reg <= 1'b0;
			pwm_s2_reg <= 1'b0;
		end else begin
			adapter_s1_reg <= adapter_present;
			adapter_s2_reg <= adapter_s1_reg;
			adapter_prev_reg <= adapter_s2_reg;
			opt_s1_reg <= {option_control_register[OPT_HS_ENABLE_BIT],
				option_control_register[OPT_LS_THRESH_BIT]};
			opt_s2_reg <= opt_s1_reg;
			mode_s1_reg <= {bootstrap_refresh, light_load, nonsync_mode};
			mode_s2_reg <= mode_s1_reg;
			pwm_s1_reg <= pwm_high;
			pwm_s2_reg <= pwm_s1_reg;
		end
	end

	// analog drops are sampled once per cycle; treated as quasi-static values
	logic signed [MV_WIDTH:0] pos_s1_reg;
	logic signed [MV_WIDTH:0] pos_s2_reg;
	logic signed [MV_WIDTH:0] sw_s1_reg;
	logic signed [MV_WIDTH:0] sw_s2_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_s1_reg <= '0;
			pos_s2_reg <= '0;
			sw_s1_reg <= '0;
			sw_s2_reg <= '0;
		end else begin
			pos_s1_reg <= adapter_sense_pos_pin_mv;
			pos_s2_reg <= pos_s1_reg;
			sw_s1_reg <= phase_node_mv;
			sw_s2_reg <= sw_s1_reg;
		end
	end

	// ----------------------------------------
	// reconnect detect
	// ----------------------------------------
	logic reconnect;
	assign reconnect = adapter_s2_reg && !adapter_prev_reg;

	// ----------------------------------------
	// phase tracking and blanking
	// ----------------------------------------
	phase_t phase_reg;
	phase_t phase_next;
	logic [BLANK_WIDTH-1:0] blank_reg;
	logic latch_reg;
	logic low_allowed;

	// no bottom gate in nonsync mode
	// light load keeps bottom off unless refresh
	assign low_allowed = !mode_s2_reg[0] && (!mode_s2_reg[1] || mode_s2_reg[2]);

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			PH_IDLE: begin
				if (adapter_s2_reg) begin
					phase_next = pwm_s2_reg ? PH_HIGH : PH_LOW;
				end
			end
			PH_HIGH: begin
				if (!pwm_s2_reg) begin
					phase_next = low_allowed ? PH_LOW : PH_OFF;
				end
			end
			PH_LOW, PH_OFF: begin
				if (pwm_s2_reg) begin
					phase_next = PH_HIGH;
				end else if (low_allowed) begin
					phase_next = PH_LOW;
				end else begin
					phase_next = PH_OFF;
				end
			end
			default: phase_next = PH_IDLE;
		endcase
		if (latch_reg || !adapter_s2_reg) begin
			phase_next = PH_IDLE;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= PH_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// blank after each gate turn-on
	// a shorter blank would judge the drop of the phase just left
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			blank_reg <= '0;
		end else if (phase_next != phase_reg) begin
			blank_reg <= '0;
		end else if (blank_reg != BLANK_LAST) begin
			blank_reg <= blank_reg + 2'h1;
		end
	end

	logic sense_ok;
	assign sense_ok = (blank_reg == BLANK_LAST);

	// ----------------------------------------
	// comparators
	// ----------------------------------------
	logic [MV_WIDTH-1:0] ls_thresh;
	logic signed [MV_WIDTH+1:0] hs_drop;
	logic hs_cmp;
	logic ls_cmp;

	assign ls_thresh = opt_s2_reg[0] ? MV_WIDTH'(LS_THRESH_HI_MV) : MV_WIDTH'(LS_THRESH_LO_MV);
	assign hs_drop = 14'(pos_s2_reg) - 14'(sw_s2_reg);
	assign hs_cmp = opt_s2_reg[1] && phase_reg == PH_HIGH && sense_ok
		&& hs_drop > $signed({2'h0, MV_WIDTH'(HS_THRESH_MV)});
	// switch node to ground while bottom on
	assign ls_cmp = phase_reg == PH_LOW && sense_ok
		&& sw_s2_reg > $signed({1'b0, ls_thresh});

	// ----------------------------------------
	// counters and latch
	// ----------------------------------------
	logic hs_limit;
	logic ls_limit;

	short_counter u_hs_count (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clear(reconnect),
		.trip(hs_cmp),
		.limit_hit(hs_limit)
	);

	short_counter u_ls_count (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clear(reconnect),
		.trip(ls_cmp),
		.limit_hit(ls_limit)
	);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_reg <= 1'b0;
		end else if (reconnect) begin
			latch_reg <= 1'b0;
		end else if (hs_limit || ls_limit) begin
			latch_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			high_gate <= 1'b0;
			low_gate <= 1'b0;
			latched_off <= 1'b0;
			hs_trip <= 1'b0;
			ls_trip <= 1'b0;
		end else begin
			high_gate <= (phase_next == PH_HIGH);
			low_gate <= (phase_next == PH_LOW);
			latched_off <= latch_reg;
			hs_trip <= hs_cmp;
			ls_trip <= ls_cmp;
		end
	end

endmodule : short_protect

`default_nettype wire

/* File: short_protect_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module short_protect_checker
	import scp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic adapter_present,
	input wire logic [scp_pkg::OPT_WIDTH-1:0] option_control_register,
	input wire logic nonsync_mode,
	input wire logic light_load,
	input wire logic bootstrap_refresh,
	input wire logic pwm_high,
	input wire logic signed [scp_pkg::MV_WIDTH:0] adapter_sense_pos_pin_mv,
	input wire logic signed [scp_pkg::MV_WIDTH:0] phase_node_mv,
	input wire logic high_gate,
	input wire logic low_gate,
	input wire logic latched_off,
	input wire logic hs_trip,
	input wire logic ls_trip
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ----
	// checks
	// ----
	// gates drop on the same edge as the latch flag shows
	property p_off; latched_off |-> !high_gate && !low_gate; endproperty
	a_off: assert property (p_off) else $error("gate on while latched");
	// steady adapter long enough to cover the sync stages
	property p_hold; adapter_present [*8] ##0 latched_off |=> latched_off; endproperty
	a_hold: assert property (p_hold) else $error("latch lost");
	property p_rise; $rose(latched_off) |-> $past(hs_trip) || $past(ls_trip); endproperty
	a_rise: assert property (p_rise) else $error("latch without trip");
	property p_ns; nonsync_mode [*5] |-> !low_gate; endproperty
	a_ns: assert property (p_ns) else $error("bottom on in nonsync");
	property p_ll; (light_load && !bootstrap_refresh) [*5] |-> !low_gate; endproperty
	a_ll: assert property (p_ll) else $error("bottom on at light load");
	property p_hsd; !option_control_register[OPT_HS_ENABLE_BIT] [*5] |-> !hs_trip; endproperty
	a_hsd: assert property (p_hsd) else $error("top trip while disabled");
	property p_neg; (phase_node_mv < 0) [*5] |-> !ls_trip; endproperty
	a_neg: assert property (p_neg) else $error("bottom trip on negative drop");
	property p_blk; $rose(high_gate) |-> !hs_trip ##1 !hs_trip ##1 !hs_trip; endproperty
	a_blk: assert property (p_blk) else $error("trip inside blanking");
	c_latch: cover property ($rose(latched_off));
	c_hs: cover property ($rose(hs_trip));
	c_ls: cover property ($rose(ls_trip));
endmodule : short_protect_checker
bind short_protect short_protect_checker u_short_protect_checker (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.adapter_present(adapter_present),
	.option_control_register(option_control_register),
	.nonsync_mode(nonsync_mode),
	.light_load(light_load),
	.bootstrap_refresh(bootstrap_refresh),
	.pwm_high(pwm_high),
	.adapter_sense_pos_pin_mv(adapter_sense_pos_pin_mv),
	.phase_node_mv(phase_node_mv),
	.high_gate(high_gate),
	.low_gate(low_gate),
	.latched_off(latched_off),
	.hs_trip(hs_trip),
	.ls_trip(ls_trip)
);
`default_nettype wire

/* File: fet_pair_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fet_pair_model (
	input wire logic high_gate,
	input wire logic low_gate,
	input wire logic signed [12:0] vin_mv,
	input wire logic signed [12:0] hs_drop_mv,
	input wire logic signed [12:0] ls_drop_mv,
	output logic signed [12:0] adapter_sense_pos_pin_mv,
	output logic signed [12:0] phase_node_mv
);
	assign adapter_sense_pos_pin_mv = vin_mv;
	// node polarity
	// both off: inductor freewheels through the body diode
	assign phase_node_mv = high_gate ? vin_mv - hs_drop_mv : (low_gate ? ls_drop_mv : -13'sh2BC);
endmodule : fet_pair_model
`default_nettype wire

/* File: short_protect_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
	samples_checked++; \
	if ((got) !== (ex)) begin \
		n_errors++; \
		$display("Error %s expected %0h seen %0h", nm, ex, got); \
	end
module short_protect_tb;
	import scp_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic adapter_present = 1'b0;
	logic [OPT_WIDTH-1:0] opt = 16'h0100;
	logic nonsync_mode = 1'b0;
	logic light_load = 1'b0;
	logic refresh = 1'b0;
	logic pwm_high = 1'b0;
	logic signed [12:0] hs_drop = 13'sh064;
	logic signed [12:0] ls_drop = -13'sh032;
	logic signed [12:0] adapter_sense_pos_pin;
	logic signed [12:0] phn;
	logic high_gate, low_gate, latched_off, hs_trip, ls_trip;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	short_protect u_short_protect (.sys_clk(sys_clk), .arst_n(arst_n),
		.adapter_present(adapter_present), .option_control_register(opt),
		.nonsync_mode(nonsync_mode), .light_load(light_load), .bootstrap_refresh(refresh),
		.pwm_high(pwm_high), .adapter_sense_pos_pin_mv(adapter_sense_pos_pin), .phase_node_mv(phn),
		.high_gate(high_gate), .low_gate(low_gate), .latched_off(latched_off),
		.hs_trip(hs_trip), .ls_trip(ls_trip));
	fet_pair_model u_fet_pair_model (.high_gate(high_gate), .low_gate(low_gate),
		.vin_mv(13'sh0FA0), .hs_drop_mv(hs_drop), .ls_drop_mv(ls_drop),
		.adapter_sense_pos_pin_mv(adapter_sense_pos_pin), .phase_node_mv(phn));
	initial forever #50 sys_clk = ~sys_clk;
	// hang guard, tests need well under 2000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : tick
	task reconnect;
		@(posedge sys_clk) adapter_present <= 1'b0;
		tick(6);
		@(posedge sys_clk) adapter_present <= 1'b1;
		tick(6);
	endtask : reconnect
	task t_hs_latch;
		@(posedge sys_clk) hs_drop <= 13'sh3E8;
		pwm_high <= 1'b1;
		n = 0;
		for (int i = 0; i < 300 && latched_off !== 1'b1; i++) begin
			tick(1);
			n += int'(hs_trip);
		end
		// one more compare lands while the latch flag settles
		`CHK("trips to latch", SHORT_LIMIT + 1, n)
		tick(1);
		`CHK("top gate", 1'b0, high_gate)
		@(posedge sys_clk) hs_drop <= 13'sh064;
		tick(20);
		`CHK("latch held", 1'b1, latched_off)
		reconnect();
		`CHK("latch cleared", 1'b0, latched_off)
		$display("hs latch test done, %0d trips", n);
	endtask : t_hs_latch
	task t_hs_off;
		@(posedge sys_clk) opt <= 16'h0000;
		hs_drop <= 13'sh3E8;
		n = 0;
		repeat (40) begin
			tick(1);
			n += int'(hs_trip);
		end
		`CHK("top check off", 1'b1, n == 0 && latched_off === 1'b0)
		@(posedge sys_clk) opt <= 16'h0100;
		hs_drop <= 13'sh064;
		$display("hs disable test done");
	endtask : t_hs_off
	task t_ls(input logic [15:0] o, input logic signed [12:0] d, input logic ex);
		@(posedge sys_clk) opt <= o;
		pwm_high <= 1'b0;
		ls_drop <= d;
		n = 0;
		repeat (20) begin
			tick(1);
			n += int'(ls_trip);
		end
		`CHK("bottom trip", ex, n > 0)
		@(posedge sys_clk) ls_drop <= -13'sh032;
		reconnect();
		$display("ls test %0h %0d done", o, d);
	endtask : t_ls
	task t_low_off;
		@(posedge sys_clk) nonsync_mode <= 1'b1;
		tick(8);
		`CHK("bottom nonsync", 1'b0, low_gate)
		@(posedge sys_clk) nonsync_mode <= 1'b0;
		light_load <= 1'b1;
		tick(8);
		`CHK("bottom light", 1'b0, low_gate)
		@(posedge sys_clk) refresh <= 1'b1;
		tick(8);
		`CHK("bottom refresh", 1'b1, low_gate)
		@(posedge sys_clk) light_load <= 1'b0;
		refresh <= 1'b0;
		$display("bottom gate test done");
	endtask : t_low_off
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(posedge sys_clk);
		`CHK("reset latch", 1'b0, latched_off)
		arst_n <= 1'b1;
		adapter_present <= 1'b1;
		tick(8);
		t_hs_latch();
		t_hs_latch();
		t_hs_off();
		t_ls(16'h0100, -13'sh190, 1'b0);
		t_ls(16'h0100, 13'sh0C8, 1'b1);
		t_ls(16'h0180, 13'sh0C8, 1'b0);
		t_ls(16'h0180, 13'sh12C, 1'b1);
		t_low_off();
		tally_and_finish();
	end
endmodule : short_protect_tb
`default_nettype wire
